/* hdl/irq_enable_regs.sv */
// Interrupt enable, identification and scratch registers on AXI4-Lite.
`timescale 1ns/100ps
// Contract
// - Enable bit 6 resets to zero; when set, clock-ready events interrupt.
// - Enable bit 5 resets to zero; when set, suspended events interrupt.
// - Control write requests suspend; frame starts halt when all suspend.
// - Enable bit 4 resets to zero; operational block events then interrupt.
// - Enable bit 2 resets to zero; transfer-complete events then interrupt.
// - Enable bit 1 resets to zero; async list events then interrupt.
// - Enable bit 0 resets to zero; frame-start events then interrupt.
// - Read-only identification word at code 27H; writes ignored.
// - Identification upper byte is product, lower byte is revision.
// - Scratch word read 28H, written A8H, resets to zero.
// - Enable read at 25H, written at A5H, bits match status.
// - Interrupt needs set status, its enable, and global enable bit.
module irq_enable_regs
  import irq_regs_pkg::*;
#(
  parameter logic [15:0] IDENT_VALUE = IDENT_DEFAULT
) (
  input wire logic CORE_CLK,
  input wire logic RESET,
  input wire logic [ADDR_W-1:0] AWADDR,
  input wire logic AWVALID,
  output logic AWREADY,
  input wire logic [31:0] WDATA,
  input wire logic [3:0] WSTRB,
  input wire logic WVALID,
  output logic WREADY,
  output logic [1:0] BRESP,
  output logic BVALID,
  input wire logic BREADY,
  input wire logic [ADDR_W-1:0] ARADDR,
  input wire logic ARVALID,
  output logic ARREADY,
  output logic [31:0] RDATA,
  output logic [1:0] RRESP,
  output logic RVALID,
  input wire logic RREADY,
  input wire events_t EVENTS,
  input wire logic ALL_DOWNSTREAM_SUSPENDED,
  output logic SUSPEND_REQUEST,
  output logic FRAME_START_ENABLE,
  output logic INT
);

  logic [15:0] enable;
  logic [15:0] scratch;
  logic [15:0] status;
  logic [15:0] hwsetup;
  logic [15:0] corectl;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  function automatic logic [7:0] reg_index(input logic [ADDR_W-1:0] a);
    reg_index = a[9:2];
  endfunction

  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
  endfunction

  // Write address and data are taken in either order.
  assign AWREADY = !aw_held && !BVALID;
  assign WREADY = !w_held && !BVALID;
  wire aw_take = AWVALID && AWREADY;
  wire w_take = WVALID && WREADY;
  wire aw_have = aw_held || aw_take;
  wire w_have = w_held || w_take;
  wire do_write = aw_have && w_have && !BVALID;
  wire [ADDR_W-1:0] wr_addr = aw_held ? aw_addr : AWADDR;
  wire [31:0] wr_data = w_held ? w_data : WDATA;
  wire [3:0] wr_strb = w_held ? w_strb : WSTRB;
  wire [7:0] wr_idx = reg_index(wr_addr);
  wire wr_enable = do_write && (wr_idx == IDX_ENABLE_WR);
  wire wr_scratch = do_write && (wr_idx == IDX_SCRATCH_WR);
  wire wr_status = do_write && (wr_idx == IDX_STATUS);
  wire wr_hwsetup = do_write && (wr_idx == IDX_HWSETUP);
  wire wr_corectl = do_write && (wr_idx == IDX_CORECTL);
  wire wr_known = wr_enable || wr_scratch || wr_status || wr_hwsetup ||
                  wr_corectl;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= '0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      BVALID <= 1'b0;
      BRESP <= RESP_OKAY;
    end else begin
      if (aw_take && !do_write) begin
        aw_held <= 1'b1;
        aw_addr <= AWADDR;
      end
      if (w_take && !do_write) begin
        w_held <= 1'b1;
        w_data <= WDATA;
        w_strb <= WSTRB;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        BVALID <= 1'b1;
        BRESP <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end else if (BVALID && BREADY) begin
        BVALID <= 1'b0;
      end
    end
  end

  // Register storage; reserved enable bits never store a one.
  wire [15:0] next_enable = merge16(enable, wr_data, wr_strb) & ENABLE_MASK;
  wire [15:0] next_scratch = merge16(scratch, wr_data, wr_strb);
  wire [15:0] next_hwsetup = merge16(hwsetup, wr_data, wr_strb) & HWSETUP_MASK;
  wire [15:0] next_corectl = merge16(corectl, wr_data, wr_strb) & CORECTL_SUSP;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      enable <= ENABLE_RESET;
      scratch <= SCRATCH_RESET;
      hwsetup <= 16'h0000;
      corectl <= 16'h0000;
    end else begin
      if (wr_enable) begin
        enable <= next_enable;
      end
      if (wr_scratch) begin
        scratch <= next_scratch;
      end
      if (wr_hwsetup) begin
        hwsetup <= next_hwsetup;
      end
      if (wr_corectl) begin
        corectl <= next_corectl;
      end
    end
  end

  // Sticky event status; set wins over write-one-to-clear.
  wire [15:0] ev_vec = {9'h000, EVENTS.clock_stable_event, EVENTS.suspended,
                        EVENTS.operational_block_event, 1'b0,
                        EVENTS.transfer_complete_event,
                        EVENTS.async_transfer_list, EVENTS.frame_start};
  wire [15:0] clr_vec = wr_status ? (wr_data[15:0] &
                        {{8{wr_strb[1]}}, {8{wr_strb[0]}}}) : 16'h0000;

  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : g_status
      always_ff @(posedge CORE_CLK or posedge RESET) begin
        if (RESET) begin
          status[g] <= 1'b0;
        end else if (ev_vec[g] && ENABLE_MASK[g]) begin
          status[g] <= 1'b1;
        end else if (clr_vec[g]) begin
          status[g] <= 1'b0;
        end
      end
    end
  endgenerate

  assign INT = |(status & enable & ENABLE_MASK) && hwsetup[0];
  assign SUSPEND_REQUEST = corectl[0];
  assign FRAME_START_ENABLE = !(corectl[0] && ALL_DOWNSTREAM_SUSPENDED);

  // Read channel: one read at a time, answer one cycle after acceptance.
  assign ARREADY = !RVALID;
  wire ar_take = ARVALID && ARREADY;
  wire [7:0] rd_idx = reg_index(ARADDR);
  wire rd_enable = rd_idx == IDX_ENABLE;
  wire rd_ident = rd_idx == IDX_IDENT;
  wire rd_scratch = rd_idx == IDX_SCRATCH;
  wire rd_status = rd_idx == IDX_STATUS;
  wire rd_hwsetup = rd_idx == IDX_HWSETUP;
  wire rd_corectl = rd_idx == IDX_CORECTL;
  wire [15:0] rd_word;
  wire rd_known;

  assign rd_word = rd_enable ? (enable & ENABLE_MASK) :
                   rd_ident ? IDENT_VALUE :
                   rd_scratch ? scratch :
                   rd_status ? status :
                   rd_hwsetup ? hwsetup :
                   rd_corectl ? corectl : 16'h0000;
  assign rd_known = rd_enable || rd_ident || rd_scratch || rd_status ||
                    rd_hwsetup || rd_corectl;

  always_ff @(posedge CORE_CLK or posedge RESET) begin
    if (RESET) begin
      RVALID <= 1'b0;
      RDATA <= 32'h0000_0000;
      RRESP <= RESP_OKAY;
    end else if (ar_take) begin
      RVALID <= 1'b1;
      RDATA <= {16'h0000, rd_word};
      RRESP <= rd_known ? RESP_OKAY : RESP_SLVERR;
    end else if (RVALID && RREADY) begin
      RVALID <= 1'b0;
    end
  end

  // Checks.
  property p_int_gate;
    @(posedge CORE_CLK) disable iff (RESET)
      INT |-> (hwsetup[0] && |(status & enable));
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("bad irq gate");

  property p_int_off;
    @(posedge CORE_CLK) disable iff (RESET)
      (wr_hwsetup && wr_strb[0] && !wr_data[0]) |=> !INT;
  endproperty
  a_int_off: assert property (p_int_off) else $error("irq not off");

  property p_clock_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.clock_stable_event && enable[BIT_CLOCK] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_clock_irq: assert property (p_clock_irq) else $error("no clk irq");

  property p_susp_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.suspended && enable[BIT_SUSP] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_susp_irq: assert property (p_susp_irq) else $error("no susp irq");

  property p_oper_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.operational_block_event && enable[BIT_OPER] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_oper_irq: assert property (p_oper_irq) else $error("no oper irq");

  property p_xfer_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.transfer_complete_event && enable[BIT_XFER] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_xfer_irq: assert property (p_xfer_irq) else $error("no xfer irq");

  property p_async_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.async_transfer_list && enable[BIT_ASYNC] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_async_irq: assert property (p_async_irq) else $error("no list irq");

  property p_frame_irq;
    @(posedge CORE_CLK) disable iff (RESET)
      (EVENTS.frame_start && enable[BIT_FRAME] && hwsetup[0] &&
       !wr_enable && !wr_hwsetup) |=> INT;
  endproperty
  a_frame_irq: assert property (p_frame_irq) else $error("no sof irq");

  property p_ident_read;
    @(posedge CORE_CLK) disable iff (RESET)
      (ar_take && rd_ident) |=> (RVALID && RDATA == {16'h0000, IDENT_VALUE});
  endproperty
  a_ident_read: assert property (p_ident_read)
    else $error("bad id");

  property p_scratch_store;
    @(posedge CORE_CLK) disable iff (RESET)
      (wr_scratch && wr_strb[1:0] == 2'b11) |=>
        scratch == $past(wr_data[15:0]);
  endproperty
  a_scratch_store: assert property (p_scratch_store)
    else $error("scratch");

  property p_reserved_zero;
    @(posedge CORE_CLK) disable iff (RESET)
      (enable & ~ENABLE_MASK) == 16'h0000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero)
    else $error("rsvd");

  property p_enable_write;
    @(posedge CORE_CLK) disable iff (RESET)
      (wr_enable && wr_strb[0]) |=>
        enable[6:0] == ($past(wr_data[6:0]) & 7'h77);
  endproperty
  a_enable_write: assert property (p_enable_write) else $error("en wr");

  property p_suspend_sof;
    @(posedge CORE_CLK) disable iff (RESET)
      (SUSPEND_REQUEST && ALL_DOWNSTREAM_SUSPENDED) |-> !FRAME_START_ENABLE;
  endproperty
  a_suspend_sof: assert property (p_suspend_sof) else $error("sof on");

  c_write: cover property (@(posedge CORE_CLK) disable iff (RESET)
    BVALID && BREADY);
  c_read: cover property (@(posedge CORE_CLK) disable iff (RESET)
    RVALID && RREADY);
  c_int: cover property (@(posedge CORE_CLK) disable iff (RESET) $rose(INT));

endmodule

/* shared/irq_regs_pkg.sv */
// Package with register map, field positions and reset values of the block.
package irq_regs_pkg;

  // Printed codes are register indices; byte address is four times the index.
  localparam logic [7:0] IDX_STATUS = 8'h24;
  localparam logic [7:0] IDX_ENABLE = 8'h25;
  localparam logic [7:0] IDX_ENABLE_WR = 8'hA5;
  localparam logic [7:0] IDX_IDENT = 8'h27;
  localparam logic [7:0] IDX_SCRATCH = 8'h28;
  localparam logic [7:0] IDX_SCRATCH_WR = 8'hA8;
  localparam logic [7:0] IDX_HWSETUP = 8'h20;
  localparam logic [7:0] IDX_CORECTL = 8'h01;

  localparam int ADDR_W = 12;

  // Event bit positions shared by status and enable.
  localparam int BIT_FRAME = 0;
  localparam int BIT_ASYNC = 1;
  localparam int BIT_XFER = 2;
  localparam int BIT_OPER = 4;
  localparam int BIT_SUSP = 5;
  localparam int BIT_CLOCK = 6;
  localparam int NUM_EVENTS = 7;

  // Bits 15..7 and bit 3 are reserved.
  localparam logic [15:0] ENABLE_MASK = 16'h0077;
  localparam logic [15:0] ENABLE_RESET = 16'h0000;
  localparam logic [15:0] SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] HWSETUP_MASK = 16'h0001;
  localparam logic [15:0] CORECTL_SUSP = 16'h0001;

  // Identification value is arbitrary.
  localparam logic [15:0] IDENT_DEFAULT = 16'h5A01;

  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  typedef struct packed {
    logic frame_start;
    logic async_transfer_list;
    logic transfer_complete_event;
    logic operational_block_event;
    logic suspended;
    logic clock_stable_event;
  } events_t;

endpackage

/* sim/axi_host_model.sv */
// Register bus master standing in for the host microprocessor.
`timescale 1ns/100ps
module axi_host_model
  import irq_regs_pkg::*;
(
  input wire logic clk,
  output logic [ADDR_W-1:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic [3:0] wstrb,
  output logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready,
  output logic [ADDR_W-1:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready
);
  initial begin
    {awaddr, awvalid, wdata, wstrb, wvalid, bready} = '0;
    {araddr, arvalid, rready} = '0;
  end
  // Readies are looked at mid-cycle, so the handshake edge is the next one.
  task automatic wr(input logic [7:0] i, input logic [15:0] d,
                    output logic [1:0] rs);
    logic ga, gw, a, w, b;
    @(posedge clk);
    awaddr <= {2'b00, i, 2'b00};
    wdata <= {16'h0000, d};
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    ga = 1'b1;
    gw = 1'b1;
    while (ga || gw) begin
      @(negedge clk);
      a = ga && awready;
      w = gw && wready;
      @(posedge clk);
      ga = ga && !a;
      gw = gw && !w;
      awvalid <= ga;
      wvalid <= gw;
    end
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      b = bvalid;
      rs = bresp;
      @(posedge clk);
    end
    bready <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] i, output logic [31:0] d,
                    output logic [1:0] rs);
    logic b;
    @(posedge clk);
    araddr <= {2'b00, i, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      b = arready;
      @(posedge clk);
    end
    arvalid <= 1'b0;
    b = 1'b0;
    while (!b) begin
      @(negedge clk);
      b = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge clk);
    end
    rready <= 1'b0;
  endtask
endmodule

/* sim/host_irq_enable_and_misc_regs_test.sv */
// Self-checking bench for the interrupt enable and scratch registers.
`timescale 1ns/100ps
module host_irq_enable_and_misc_regs_test
  import irq_regs_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic dn = 1'b0;
  events_t ev = '0;
  int fails = 0;
  int tests_run = 0;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, susp, fse, irq;
  always #2.5 clk = ~clk;
  irq_enable_regs dut_u (
    .CORE_CLK(clk), .RESET(rst), .AWADDR(awaddr), .AWVALID(awvalid),
    .AWREADY(awready), .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid),
    .WREADY(wready), .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
    .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
    .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready),
    .EVENTS(ev), .ALL_DOWNSTREAM_SUSPENDED(dn), .SUSPEND_REQUEST(susp),
    .FRAME_START_ENABLE(fse), .INT(irq)
  );
  axi_host_model host_u (
    .clk, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready
  );
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic w(input logic [7:0] i, input logic [15:0] d,
                   input logic [1:0] er);
    logic [1:0] rs;
    host_u.wr(i, d, rs);
    check({30'h0, rs}, {30'h0, er});
  endtask
  task automatic r(input logic [7:0] i, input logic [31:0] e,
                   input logic [1:0] er);
    logic [31:0] d;
    logic [1:0] rs;
    host_u.rd(i, d, rs);
    check(d, e);
    check({30'h0, rs}, {30'h0, er});
  endtask
  task automatic pulse(input int b);
    events_t e;
    e = '0;
    e[b < 3 ? 5 - b : 6 - b] = 1'b1;
    @(posedge clk);
    ev <= e;
    @(posedge clk);
    ev <= '0;
    @(negedge clk);
  endtask
  task automatic t_reset();
    r(IDX_ENABLE, 32'h0, RESP_OKAY);
    r(IDX_SCRATCH, 32'h0, RESP_OKAY);
    r(IDX_IDENT, {16'h0000, IDENT_DEFAULT}, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    $display("reset values test done");
  endtask
  task automatic t_regs();
    w(IDX_ENABLE_WR, 16'hFFFF, RESP_OKAY);
    r(IDX_ENABLE, 32'h00000077, RESP_OKAY);
    w(IDX_ENABLE, 16'h0000, RESP_SLVERR);
    r(IDX_ENABLE, 32'h00000077, RESP_OKAY);
    w(IDX_IDENT, 16'h0000, RESP_SLVERR);
    r(IDX_IDENT, {16'h0000, IDENT_DEFAULT}, RESP_OKAY);
    w(IDX_SCRATCH_WR, 16'hA5C3, RESP_OKAY);
    w(IDX_SCRATCH, 16'h1234, RESP_SLVERR);
    r(IDX_SCRATCH, 32'h0000A5C3, RESP_OKAY);
    r(8'h30, 32'h0, RESP_SLVERR);
    w(IDX_ENABLE_WR, 16'h0000, RESP_OKAY);
    $display("register access test done");
  endtask
  task automatic t_irq();
    int bits[6] = '{0, 1, 2, 4, 5, 6};
    logic [15:0] m;
    w(IDX_HWSETUP, 16'h0001, RESP_OKAY);
    foreach (bits[k]) begin
      m = 16'h0001 << bits[k];
      pulse(bits[k]);
      check({31'h0, irq}, 32'h0);
      r(IDX_STATUS, {16'h0000, m}, RESP_OKAY);
      w(IDX_ENABLE_WR, 16'h0077 ^ m, RESP_OKAY);
      @(negedge clk);
      check({31'h0, irq}, 32'h0);
      w(IDX_ENABLE_WR, m, RESP_OKAY);
      @(negedge clk);
      check({31'h0, irq}, 32'h1);
      w(IDX_HWSETUP, 16'h0000, RESP_OKAY);
      @(negedge clk);
      check({31'h0, irq}, 32'h0);
      w(IDX_HWSETUP, 16'h0001, RESP_OKAY);
      w(IDX_STATUS, m, RESP_OKAY);
      @(negedge clk);
      check({31'h0, irq}, 32'h0);
      pulse(bits[k]);
      check({31'h0, irq}, 32'h1);
      w(IDX_STATUS, m, RESP_OKAY);
      @(negedge clk);
      check({31'h0, irq}, 32'h0);
      w(IDX_ENABLE_WR, 16'h0000, RESP_OKAY);
    end
    $display("interrupt test done");
  endtask
  task automatic t_susp();
    @(posedge clk);
    dn <= 1'b1;
    @(negedge clk);
    check({30'h0, susp, fse}, 32'h1);
    w(IDX_CORECTL, 16'h0001, RESP_OKAY);
    @(negedge clk);
    check({30'h0, susp, fse}, 32'h2);
    @(posedge clk);
    dn <= 1'b0;
    @(negedge clk);
    check({30'h0, susp, fse}, 32'h3);
    w(IDX_CORECTL, 16'h0000, RESP_OKAY);
    $display("suspend test done");
  endtask
  task automatic t_rst();
    w(IDX_SCRATCH_WR, 16'h3C5A, RESP_OKAY);
    w(IDX_ENABLE_WR, 16'h0041, RESP_OKAY);
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    r(IDX_SCRATCH, 32'h0, RESP_OKAY);
    r(IDX_ENABLE, 32'h0, RESP_OKAY);
    check({31'h0, irq}, 32'h0);
    $display("mid-run reset test done");
  endtask
  task automatic print_verdict();
    $display("tests_run=%0d fails=%0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_irq();
    t_susp();
    t_rst();
    print_verdict();
  end
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    print_verdict();
  end
endmodule
